// *** hw/sbsi_pkg.sv ***
// sbsi_pkg: shared constants and types of the burst static RAM command block
// assumes a single 40 MHz clock and pins sampled synchronously to it
package sbsi_pkg;

  // ==========================================================================
  // data and address geometry
  localparam int DATA_W     = 72;  // full data bus width
  localparam int LANES      = 8;   // byte lanes on the data bus
  localparam int BYTE_W     = 9;   // bits per byte lane
  localparam int ADDR_W     = 19;  // word address width
  localparam int BURST_W    = 2;   // burst counter width
  localparam int FIFO_DEPTH = 4;   // write buffer depth in words

  // ==========================================================================
  // burst counter values
  localparam logic [BURST_W-1:0] BURST_FIRST = 2'h0;  // count after a load
  localparam logic [BURST_W-1:0] BURST_STEP  = 2'h1;  // count increment

  // ==========================================================================
  // sleep timing, in clock cycles
  localparam logic [1:0] SLEEP_ENTER_CYC = 2'h2;  // high level to sleep
  localparam logic [1:0] SLEEP_WAKE_CYC  = 2'h2;  // low level to active
  localparam logic [1:0] SLEEP_CNT_INIT  = 2'h1;  // first counted cycle

  // ==========================================================================
  // power state of the device
  typedef enum logic [1:0] {
    SBSI_ACTIVE,
    SBSI_ENTERING,
    SBSI_ASLEEP,
    SBSI_WAKING
  } sbsi_slp_t;

  // kind of burst currently running
  typedef enum logic [1:0] {
    SBSI_BT_DESEL,
    SBSI_BT_READ,
    SBSI_BT_WRITE
  } sbsi_burst_t;

endpackage

// *** hw/sbsi_fifo.sv ***
// sbsi_fifo: small synchronous fifo with valid/ready on both sides
// assumes DEPTH is a power of two and one clock for both sides
`timescale 1ns/1ps
module sbsi_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         rst_b_i,
  // filling side
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  // draining side
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);

  // ==========================================================================
  // storage and pointers
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] store [DEPTH];  // word storage
  logic [AW:0]  wr_ptr;         // write pointer with wrap bit
  logic [AW:0]  rd_ptr;         // read pointer with wrap bit
  logic         full;
  logic         empty;

  // wrap bits differ and indexes match: every slot taken
  assign full        = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty       = (wr_ptr == rd_ptr);
  assign in_ready_o  = ~full;
  assign out_valid_o = ~empty;
  assign out_data_o  = store[rd_ptr[AW-1:0]];

  // ==========================================================================
  // pointer update
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      // push only when a slot is free
      if (in_valid_i && !full)
        wr_ptr <= wr_ptr + 1'b1;
      // pop only when a word is held
      if (out_ready_i && !empty)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // data slots carry no reset; valid pointers guard them
  always_ff @(posedge ref_clk_i)
  begin
    if (in_valid_i && !full)
      store[wr_ptr[AW-1:0]] <= in_data_i;
  end

endmodule

// *** hw/sbsi_sram_dev.sv ***
// sbsi_sram_dev: command decode, burst counter, late write and sleep control
// of a synchronous burst static RAM, with the core array held inside.
// assumes all pins sampled on ref_clk_i; the board resolves the data wire.
// Operation
// R01 - selected read begin loads address, starts read
// R02 - selected write with lanes loads address, writes
// R03 - write with no lanes is an abort
// R04 - continue ignores store and selects, keeps type
// R05 - every continue cycle advances burst counter
// R06 - any inactive select gives deselect, bus off
// R07 - deselect continue only after a deselect
// R08 - read with output enable high is dummy
// R09 - drivers off during writes regardless of enable
// R10 - held clock edge freezes state and bus
// R11 - outputs off during power-up
// R12 - counter returns to start after four accesses
// R13 - linear order steps low address modulo four
// R14 - interleaved order is start xor count
// R15 - flow select low flow-through, else pipelined
// R16 - sleep pin pulled down, flow pin up
// R17 - sleep entered two cycles after request
// R18 - wake two cycles after request falls
// R19 - asleep: deselected, inputs ignored, bus off
// R20 - controller finishes operations before sleep
// R21 - only reads or deselects during sleep recovery
// R22 - pipelined read data one edge later
// R23 - pipelined write data on third edge
// R24 - flow-through write data on second edge
// R25 - order and flow pins stay static
// R26 - lane mask travels with the late write
`timescale 1ns/1ps
module sbsi_sram_dev #(
  parameter int ADDR_W     = sbsi_pkg::ADDR_W,
  parameter int FIFO_DEPTH = sbsi_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                          ref_clk_i,
  input  wire logic                          rst_b_i,
  // synchronous command pins
  input  wire logic                          clock_hold_n_i,
  input  wire logic                          burst_step_i,
  input  wire logic                          store_n_i,
  input  wire logic [sbsi_pkg::LANES-1:0]    byte_write_n_i,
  input  wire logic                          chip_sel1_n_i,
  input  wire logic                          chip_sel2_i,
  input  wire logic                          chip_sel3_n_i,
  input  wire logic [ADDR_W-1:0]             addr_i,
  input  wire logic                          out_enable_n_i,
  // mode pins; a low _drv_i means the pin floats
  input  wire logic                          sleep_req_i,
  input  wire logic                          sleep_req_drv_i,
  input  wire logic                          burst_order_linear_n_i,
  input  wire logic                          flow_sel_n_i,
  input  wire logic                          flow_sel_drv_i,
  // data bus as input, output and enable
  input  wire logic [sbsi_pkg::DATA_W-1:0]   data_in_i,
  output logic      [sbsi_pkg::DATA_W-1:0]   data_out_o,
  output logic                               data_oe_o
);

  // ==========================================================================
  // declarations
  localparam int LN = sbsi_pkg::LANES;
  localparam int BW = sbsi_pkg::BYTE_W;
  localparam int DW = sbsi_pkg::DATA_W;
  localparam int CW = sbsi_pkg::BURST_W;
  localparam int FW = ADDR_W + LN + DW;  // fifo word: address, lanes, data

  sbsi_pkg::sbsi_slp_t   st;         // power state
  sbsi_pkg::sbsi_burst_t btype;      // running burst kind
  logic [1:0]            slp_cnt;    // sleep entry / wake counter
  logic                  sleep_eff;  // sleep request after pull-down
  logic                  pipe_mode;  // pipelined when high
  logic                  awake;      // commands accepted
  logic                  go;         // this edge acts
  logic                  selected;   // all three selects active
  logic                  no_lane;    // every lane strobe high
  logic                  rd_begin;
  logic                  wr_begin;
  logic                  ab_begin;   // write abort begin
  logic                  rd_cont;
  logic                  wr_cont;
  logic                  cmd_rd;     // read access this edge
  logic                  cmd_wr;     // real write access this edge
  logic [ADDR_W-1:0]     cmd_addr;   // address used this edge
  logic [ADDR_W-1:CW]    base_hi;    // upper address of the burst
  logic [CW-1:0]         start_low;  // loaded low address
  logic [CW-1:0]         burst_cnt;  // accesses since the load
  logic [CW-1:0]         next_cnt;
  logic [CW-1:0]         next_low;
  logic [CW-1:0]         cur_low;    // low address last used
  logic [CW-1:0]         addr_lo;
  // late write and read pipeline
  logic                  s1_rd;
  logic                  s1_wr;
  logic [ADDR_W-1:0]     s1_addr;
  logic [LN-1:0]         s1_mask;
  logic                  s2_wr;
  logic [ADDR_W-1:0]     s2_addr;
  logic [LN-1:0]         s2_mask;
  logic                  push;       // write data taken this edge
  logic [ADDR_W-1:0]     push_addr;
  logic [LN-1:0]         push_mask;
  logic                  fifo_rdy;
  logic                  d_valid;
  logic                  d_ready;
  logic [FW-1:0]         d_word;
  logic                  drain;
  logic [ADDR_W-1:0]     rd_addr;
  logic                  rd_fire;
  logic [DW-1:0]         rd_word;

  // ==========================================================================
  // pin defaults and command decode
  // R16 floating sleep pin reads low
  assign sleep_eff = sleep_req_drv_i & sleep_req_i;
  // R15 floating flow pin selects pipelined
  assign pipe_mode = ~flow_sel_drv_i | flow_sel_n_i;

  // R19 only an awake device takes commands
  assign awake    = (st == sbsi_pkg::SBSI_ACTIVE) || (st == sbsi_pkg::SBSI_ENTERING);
  // R10 a held edge does nothing; a full buffer also stalls
  assign go       = awake & ~clock_hold_n_i & fifo_rdy;
  assign selected = ~chip_sel1_n_i & chip_sel2_i & ~chip_sel3_n_i;
  assign no_lane  = &byte_write_n_i;
  assign addr_lo  = addr_i[CW-1:0];

  // R01 read begin
  assign rd_begin = ~burst_step_i & selected & store_n_i;
  // R02 write begin with lanes
  assign wr_begin = ~burst_step_i & selected & ~store_n_i & ~no_lane;
  // R03 write begin without lanes
  assign ab_begin = ~burst_step_i & selected & ~store_n_i & no_lane;
  // R04 continue ignores store and selects
  assign rd_cont  = burst_step_i & (btype == sbsi_pkg::SBSI_BT_READ);
  assign wr_cont  = burst_step_i & (btype == sbsi_pkg::SBSI_BT_WRITE) & ~no_lane;
  assign cmd_rd   = rd_begin | rd_cont;
  assign cmd_wr   = wr_begin | wr_cont;

  // ==========================================================================
  // burst address generation
  // R12 two-bit count wraps to the loaded address
  assign next_cnt = burst_cnt + sbsi_pkg::BURST_STEP;
  // R13 R14 linear adds, interleaved xors
  assign next_low = burst_order_linear_n_i ? (start_low ^ next_cnt)
                                           : CW'(start_low + next_cnt);
  assign cmd_addr = burst_step_i ? {base_hi, next_low} : addr_i;

  // burst kind, base and counter
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      btype     <= sbsi_pkg::SBSI_BT_DESEL;
      base_hi   <= '0;
      start_low <= sbsi_pkg::BURST_FIRST;
      burst_cnt <= sbsi_pkg::BURST_FIRST;
    end
    else if (go)
    begin
      // R05 any continue advances, dummy and abort ones too
      if (burst_step_i)
        burst_cnt <= next_cnt;
      else if (rd_begin || wr_begin)
      begin
        base_hi   <= addr_i[ADDR_W-1:CW];
        start_low <= addr_lo;
        burst_cnt <= sbsi_pkg::BURST_FIRST;
        btype     <= rd_begin ? sbsi_pkg::SBSI_BT_READ : sbsi_pkg::SBSI_BT_WRITE;
      end
      // abort keeps a write burst open but loads nothing
      else if (ab_begin)
        btype <= sbsi_pkg::SBSI_BT_WRITE;
      // R06 R07 deselect; later continues stay deselected
      else
        btype <= sbsi_pkg::SBSI_BT_DESEL;
    end
  end

  // low address of the last access, watched by the checks below
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cur_low <= sbsi_pkg::BURST_FIRST;
    else if (go && burst_step_i)
      cur_low <= next_low;
    else if (go && (rd_begin || wr_begin))
      cur_low <= addr_lo;
  end

  // ==========================================================================
  // command pipeline
  // R26 the lane mask travels beside the address
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s1_rd   <= 1'b0;
      s1_wr   <= 1'b0;
      s1_addr <= '0;
      s1_mask <= '0;
      s2_wr   <= 1'b0;
      s2_addr <= '0;
      s2_mask <= '0;
    end
    else if (go)
    begin
      s1_rd   <= cmd_rd;
      s1_wr   <= cmd_wr;
      s1_addr <= cmd_addr;
      s1_mask <= ~byte_write_n_i;
      s2_wr   <= s1_wr;
      s2_addr <= s1_addr;
      s2_mask <= s1_mask;
    end
  end

  // R23 R24 write data taken two edges late, or one in flow-through
  assign push      = go & (pipe_mode ? s2_wr : s1_wr);
  assign push_addr = pipe_mode ? s2_addr : s1_addr;
  assign push_mask = pipe_mode ? s2_mask : s1_mask;

  // ==========================================================================
  // write buffer and core array
  // a full buffer stalls every edge; the array drains in every state but asleep
  assign d_ready = (st != sbsi_pkg::SBSI_ASLEEP);
  assign drain   = d_valid & d_ready;

  sbsi_fifo #(
    .W     (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_wbuf (
    .ref_clk_i   (ref_clk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (push),
    .in_data_i   ({push_addr, push_mask, data_in_i}),
    .in_ready_o  (fifo_rdy),
    .out_valid_o (d_valid),
    .out_data_o  (d_word),
    .out_ready_i (d_ready)
  );

  // R22 pipelined reads use the registered address
  assign rd_addr = pipe_mode ? s1_addr : cmd_addr;
  assign rd_fire = go & (pipe_mode ? s1_rd : cmd_rd);

  // one array per lane so each lane writes alone
  for (genvar l = 0; l < LN; l++)
  begin : g_lane
    logic [BW-1:0] mem [2**ADDR_W];  // lane storage, no reset

    // R02 only enabled lanes are written
    always_ff @(posedge ref_clk_i)
    begin
      if (drain && d_word[DW+l])
        mem[d_word[FW-1:LN+DW]] <= d_word[l*BW +: BW];
    end

    assign rd_word[l*BW +: BW] = mem[rd_addr];
  end

  // ==========================================================================
  // output register and driver enable
  // read data is only loaded on acting edges, so a held edge keeps it
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      data_out_o <= '0;
    else if (rd_fire)
      data_out_o <= rd_word;
  end

  // enable is registered, so the enable pin acts one edge late
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    // R11 bus off from power-up
    if (!rst_b_i)
      data_oe_o <= 1'b0;
    // R19 asleep or waking keeps the bus off
    else if (!awake)
      data_oe_o <= 1'b0;
    // R08 R09 only reads drive, and only with enable low
    else if (go)
      data_oe_o <= (pipe_mode ? s1_rd : cmd_rd) & ~out_enable_n_i;
    // R10 held edge keeps a read driving, still enable gated
    else
      data_oe_o <= data_oe_o & ~out_enable_n_i;
  end

  // ==========================================================================
  // sleep control
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st      <= sbsi_pkg::SBSI_ACTIVE;
      slp_cnt <= '0;
    end
    else
    begin
      case (st)
        sbsi_pkg::SBSI_ACTIVE:
        begin
          // R17 start counting the entry delay
          if (sleep_eff)
          begin
            st      <= sbsi_pkg::SBSI_ENTERING;
            slp_cnt <= sbsi_pkg::SLEEP_CNT_INIT;
          end
        end
        sbsi_pkg::SBSI_ENTERING:
        begin
          // short request aborts entry
          if (!sleep_eff)
            st <= sbsi_pkg::SBSI_ACTIVE;
          // R17 asleep two cycles after the request
          else if (slp_cnt == sbsi_pkg::SLEEP_ENTER_CYC - 2'h1)
            st <= sbsi_pkg::SBSI_ASLEEP;
          else
            slp_cnt <= slp_cnt + 2'h1;
        end
        sbsi_pkg::SBSI_ASLEEP:
        begin
          // R18 start counting the wake delay
          if (!sleep_eff)
          begin
            st      <= sbsi_pkg::SBSI_WAKING;
            slp_cnt <= sbsi_pkg::SLEEP_CNT_INIT;
          end
        end
        sbsi_pkg::SBSI_WAKING:
        begin
          if (sleep_eff)
            st <= sbsi_pkg::SBSI_ASLEEP;
          // R18 normal again two cycles after release
          else if (slp_cnt == sbsi_pkg::SLEEP_WAKE_CYC - 2'h1)
            st <= sbsi_pkg::SBSI_ACTIVE;
          else
            slp_cnt <= slp_cnt + 2'h1;
        end
        default:
          st <= sbsi_pkg::SBSI_ACTIVE;
      endcase
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_pipe_rd;
    (go && rd_begin && pipe_mode && !out_enable_n_i) ##1 (go && !out_enable_n_i);
  endsequence

  sequence s_pipe_wr;
    (go && wr_begin && pipe_mode) ##1 go ##1 go;
  endsequence

  sequence s_wrap;
    (go && (rd_begin || wr_begin)) ##1 (go && burst_step_i)[*4];
  endsequence

  sequence s_sleep_in;
    (st == sbsi_pkg::SBSI_ACTIVE && sleep_eff) ##1 sleep_eff;
  endsequence

  sequence s_sleep_out;
    (st == sbsi_pkg::SBSI_ASLEEP && !sleep_eff) ##1 !sleep_eff;
  endsequence

  // R01 address registered for reads
  a_rd_load: assert property (go && rd_begin |=> s1_rd && s1_addr == $past(addr_i)) // R01
    else $error("read begin did not load address");
  // R02 lanes registered with write
  a_wr_load: assert property (go && wr_begin |=> s1_wr && s1_mask == ~$past(byte_write_n_i)) // R02
    else $error("write begin lost lane mask");
  // R03 abort writes nothing
  a_abort_nop: assert property (go && no_lane && (ab_begin || burst_step_i) |=> !s1_wr) // R03
    else $error("write abort produced a write");
  // R04 continue keeps read type
  a_cont_type: assert property (go && rd_cont |=> s1_rd && !s1_wr) // R04
    else $error("read continue lost burst type");
  // R05 counter steps on continue
  a_cnt_step: assert property (go && burst_step_i |=> burst_cnt == CW'($past(burst_cnt) + 2'h1)) // R05
    else $error("burst counter did not advance");
  // R06 deselect ends the burst
  a_desel_cyc: assert property (go && !burst_step_i && !selected |=>
                                btype == sbsi_pkg::SBSI_BT_DESEL && !s1_rd && !s1_wr) // R06
    else $error("deselect cycle started an access");
  // R08 dummy read keeps bus off
  a_dummy_rd: assert property (go && cmd_rd && !pipe_mode && out_enable_n_i |=> !data_oe_o) // R08
    else $error("dummy read drove the bus");
  // R09 pipelined writes never drive
  a_wr_nodrv: assert property (go && cmd_wr && pipe_mode ##1 go |=> !data_oe_o) // R09
    else $error("bus driven during write");
  // R10 held edge freezes state
  a_hold_keep: assert property (clock_hold_n_i |=> $stable(burst_cnt) && $stable(data_out_o)
                                && $stable(s1_addr)) // R10
    else $error("held clock edge changed state");
  // R12 fifth access reuses the start
  a_wrap: assert property (s_wrap |=> cur_low == $past(addr_lo, 5)) // R12
    else $error("burst did not wrap to start address");
  // R13 linear order
  a_linear: assert property (go && burst_step_i && !burst_order_linear_n_i |=>
                             cur_low == CW'($past(cur_low) + 2'h1)) // R13
    else $error("linear burst step wrong");
  // R14 interleaved order
  a_interleave: assert property (go && burst_step_i && burst_order_linear_n_i |=>
                                 cur_low == ($past(start_low) ^ $past(next_cnt))) // R14
    else $error("interleaved burst step wrong");
  // R16 floating sleep pin keeps device active
  a_sleep_float: assert property (!sleep_req_drv_i && st == sbsi_pkg::SBSI_ACTIVE |=>
                                  st == sbsi_pkg::SBSI_ACTIVE) // R16
    else $error("floating sleep pin put device to sleep");
  // R17 sleep entry delay
  a_sleep_enter: assert property (s_sleep_in |=> st == sbsi_pkg::SBSI_ASLEEP) // R17
    else $error("sleep not entered after two cycles");
  // R18 wake delay
  a_sleep_wake: assert property (s_sleep_out |=> st == sbsi_pkg::SBSI_ACTIVE) // R18
    else $error("device not awake after two cycles");
  // R19 asleep device is quiet
  a_sleep_quiet: assert property (st == sbsi_pkg::SBSI_ASLEEP |=> !data_oe_o && !push
                                  && $stable(burst_cnt)) // R19
    else $error("sleeping device acted");
  // R22 pipelined read latency
  a_pipe_rd: assert property (s_pipe_rd |=> data_oe_o) // R22
    else $error("pipelined read data not driven");
  // R22 flow-through read latency
  a_flow_rd: assert property (go && rd_begin && !pipe_mode && !out_enable_n_i |=> data_oe_o) // R22
    else $error("flow-through read data not driven");
  // R23 third-edge write data with its mask
  a_wr_late: assert property (s_pipe_wr |-> push && push_mask == ~$past(byte_write_n_i, 2)) // R23
    else $error("late write data not taken on third edge");

endmodule

// *** test/sbsi_host_model.sv ***
// sbsi_host_model: host end of the shared data wire
// assumes the bench says when the host drives write data
`timescale 1ns/1ps
module sbsi_host_model (
  // clock
  input  wire logic                        ref_clk_i,
  // host write data
  input  wire logic                        drv_i,
  input  wire logic [sbsi_pkg::DATA_W-1:0] wdat_i,
  // device side and resolved wire
  input  wire logic                        dev_oe_i,
  input  wire logic [sbsi_pkg::DATA_W-1:0] dev_dat_i,
  output logic      [sbsi_pkg::DATA_W-1:0] wire_o
);
  logic [sbsi_pkg::DATA_W-1:0] last = '0;  // last wire value
  // ==========================================================
  // wire resolution
  // drive only on the data edge
  // a released wire flips each cycle so stale data never matches
  assign wire_o = dev_oe_i ? dev_dat_i : (drv_i ? wdat_i : ~last);
  // wire history
  always @(posedge ref_clk_i) last <= wire_o;
endmodule

// *** test/sync_burst_sram_interface_tb.sv ***
// sync_burst_sram_interface_tb: command bench with a queue-free slot model
// assumes a small array and inputs changed on the falling edge
`timescale 1ns/1ps
module sync_burst_sram_interface_tb;
  localparam int AW = 6;                // small array
  localparam int DW = sbsi_pkg::DATA_W; // bus width
  // ==========================================================
  // pins and model state
  logic          clk, rst_b, hold_n, step, st_n, cs1_n, cs2, cs3_n, oe_n;
  logic          zz, zz_drv, lin_n, ft_n, ft_drv, wdrv, dev_oe, asleep;
  logic [7:0]    bw, wr_m [4];
  logic [AW-1:0] addr, base, ad, rd_a [4], wr_a [4];
  logic [DW-1:0] wdat, bus, dout, mem [2**AW];
  logic          rd_v [4], rd_o [4], wr_v [4];
  logic [1:0]    btype, cnt;
  logic [31:0]   lfsr = 32'hed01;
  int            e = 0, err_count = 0, checks = 0, cyc_n = 0, ft = 0;
  sbsi_sram_dev #(.ADDR_W(AW), .FIFO_DEPTH(sbsi_pkg::FIFO_DEPTH)) i_sbsi_sram_dev (
    .ref_clk_i(clk), .rst_b_i(rst_b), .clock_hold_n_i(hold_n), .burst_step_i(step),
    .store_n_i(st_n), .byte_write_n_i(bw), .chip_sel1_n_i(cs1_n), .chip_sel2_i(cs2),
    .chip_sel3_n_i(cs3_n), .addr_i(addr), .out_enable_n_i(oe_n), .sleep_req_i(zz),
    .sleep_req_drv_i(zz_drv), .burst_order_linear_n_i(lin_n), .flow_sel_n_i(ft_n),
    .flow_sel_drv_i(ft_drv), .data_in_i(bus), .data_out_o(dout), .data_oe_o(dev_oe));
  sbsi_host_model i_sbsi_host_model (.ref_clk_i(clk), .drv_i(wdrv), .wdat_i(wdat),
    .dev_oe_i(dev_oe), .dev_dat_i(dout), .wire_o(bus));
  // clock, 25 ns period
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // hang guard, well above both runs
  always @(posedge clk)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000)
    begin
      err_count++;
      close_out();
    end
  end
  // fixed-seed pattern source
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  // single compare point
  task automatic cmp(input logic [DW-1:0] seen, input logic [DW-1:0] exp, input string m);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // verdict
  task automatic close_out();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one acting edge: drive, model the decode, then check the bus
  task automatic cyc(input logic s, input logic w, input logic [7:0] m, input int sc,
                     input logic [AW-1:0] a, input logic o);
    int k;
    {hold_n, step, st_n, bw, addr, oe_n} = {1'b0, s, w, m, a, o};
    {cs1_n, cs2, cs3_n} = {sc == 1, sc != 2, sc == 3};
    k = (e + 1) % 4;
    wdrv = wr_v[k];
    wdat = DW'({rnd(), rnd(), rnd()});
    for (int l = 0; l < 8; l++)
      if (wr_v[k] && !wr_m[k][l]) mem[wr_a[k]][l*9 +: 9] = wdat[l*9 +: 9];
    wr_v[k] = 1'b0;
    @(posedge clk);
    e++;
    if (!asleep)
    begin
      if (!s && sc != 0) btype = 2'h0;
      else if (!s) {btype, base, cnt} = {w ? 2'h1 : 2'h2, (w || m != 8'hff) ? a : base, 2'h0};
      else cnt = cnt + 2'h1;
      ad = {base[AW-1:2], lin_n ? base[1:0] ^ cnt : base[1:0] + cnt};
      k = (e + 1 - ft) % 4;
      if (btype == 2'h1) {rd_v[k], rd_a[k], rd_o[k]} = {1'b1, ad, o};
      k = (e + 2 - ft) % 4;
      if (btype == 2'h2 && m != 8'hff) {wr_v[k], wr_a[k], wr_m[k]} = {1'b1, ad, m};
    end
    @(negedge clk);
    k = e % 4;
    if (rd_v[k]) cmp(DW'(dev_oe), DW'(!rd_o[k]), "read enable");
    if (rd_v[k] && !rd_o[k]) cmp(dout, mem[rd_a[k]], "read data");
    if (!rd_v[k]) cmp(DW'(dev_oe), DW'(1'b0), "bus released");
    rd_v[k] = 1'b0;
  endtask
  // ignored edge mid-read
  task automatic hold();
    logic [DW-1:0] d;
    logic          o;
    {hold_n, d, o} = {1'b1, dout, dev_oe};
    @(posedge clk);
    @(negedge clk);
    cmp(dout, d, "held data");
    cmp(DW'(dev_oe), DW'(o), "held enable");
  endtask
  // one configuration; modes change only under reset
  task automatic run(input logic fdrv, input logic lo);
    logic [AW-1:0] a;
    {rst_b, ft_drv, ft_n, lin_n, ft, a} = {1'b0, fdrv, 1'b0, lo, 32'(fdrv), AW'(rnd())};
    for (int i = 0; i < 4; i++) {rd_v[i], wr_v[i]} = 2'h0;
    repeat (20) @(negedge clk);
    cmp(DW'(dev_oe), DW'(1'b0), "bus off in reset");
    rst_b = 1'b1;
    cyc(1'b0, 1'b0, 8'h00, 0, a, 1'b0);
    for (int i = 1; i < 4; i++) cyc(1'b1, 1'b1, 8'(rnd()) & 8'hfe, i, a, 1'b0);
    repeat (4) cyc(1'b0, 1'b1, 8'hff, 1, a, 1'b0);
    cyc(1'b0, 1'b1, 8'hff, 0, a, 1'b0);
    cyc(1'b1, 1'b0, 8'h00, 2, a, 1'b0);
    // four unbroken continues, then a held edge mid-read
    repeat (3) cyc(1'b1, 1'b1, 8'hff, 0, a, 1'b0);
    hold();
    cyc(1'b0, 1'b0, 8'h3c, 0, a ^ 6'h20, 1'b0);
    for (int i = 1; i < 4; i++) cyc(1'b0, 1'b1, 8'hff, i, a, 1'b0);
    cyc(1'b1, 1'b1, 8'hff, 0, a, 1'b0);
    cyc(1'b0, 1'b0, 8'hff, 0, a, 1'b0);
    cyc(1'b1, 1'b0, 8'hff, 0, a, 1'b0);
    cyc(1'b0, 1'b1, 8'hff, 1, a, 1'b1);
    cyc(1'b0, 1'b1, 8'hff, 0, a, 1'b1);
    cyc(1'b1, 1'b1, 8'hff, 0, a, 1'b1);
    cyc(1'b0, 1'b1, 8'hff, 1, a, 1'b1);
    // sleep only when idle; two edges still accepted
    {zz_drv, zz} = 2'h3;
    cyc(1'b0, 1'b1, 8'hff, 0, a, 1'b0);
    cyc(1'b0, 1'b1, 8'hff, 1, a, 1'b0);
    asleep = 1'b1;
    repeat (3) cyc(1'b0, 1'b1, 8'hff, 0, a, 1'b0);
    zz = 1'b0;
    repeat (2) cyc(1'b0, 1'b1, 8'hff, 0, a, 1'b0);
    asleep = 1'b0;
    cyc(1'b0, 1'b1, 8'hff, 0, a, 1'b0);
    repeat (3) cyc(1'b1, 1'b1, 8'hff, 0, a, 1'b0);
    {zz_drv, zz} = 2'h1;
    repeat (2) cyc(1'b0, 1'b1, 8'hff, 1, a, 1'b0);
    $display("test done: flow %0d interleaved %0d", fdrv, lo);
  endtask
  // main sequence: pipelined linear, then flow-through interleaved
  initial
  begin
    {rst_b, hold_n, step, st_n, bw, addr, oe_n, cs1_n, cs2, cs3_n} = '1;
    {zz, zz_drv, lin_n, ft_n, ft_drv, wdrv, wdat, asleep} = 1'b0 << 1;
    zz = 1'b1;
    run(1'b0, 1'b0);
    run(1'b1, 1'b1);
    close_out();
  end
endmodule
